//--- ext_irq_pkg.sv
package ext_irq_pkg;
  // Number of capture/compare channel pins
  localparam int NUM_CHANNELS = 16;
  localparam int TIMER_WIDTH = 16;
  localparam int SYNC_STAGES = 2;
  // Edge select codes shared by all sources (low two bits)
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Channel mode field: capture modes are 001b, 010b, 011b
  localparam int CH_MODE_WIDTH = 3;
  localparam logic [2:0] CH_MODE_CAP_RISE = 3'h1;
  localparam logic [2:0] CH_MODE_CAP_BOTH = 3'h3;
  // Auxiliary timer mode 101b selects capture
  localparam logic [2:0] AUX_MODE_CAPTURE = 3'h5;
  // Input select field: top bit ignored
  localparam int AUX_SEL_EDGE_LSB = 0;
  localparam int AUX_SEL_EDGE_MSB = 1;
  // Interrupt control field positions
  localparam int ICR_LEVEL_LSB = 2;
  localparam int ICR_LEVEL_MSB = 5;
  localparam int ICR_WIDTH = 8;
  localparam int ICR_XFER_BIT = 6;
  localparam int LEVEL_WIDTH = 4;
  localparam int SRC_IDX_WIDTH = 5;
  // Source indices for grant/vector numbering
  localparam logic [4:0] SRC_AUX_A = 5'h10;
  localparam logic [4:0] SRC_AUX_B = 5'h11;
  localparam logic [4:0] SRC_RELOAD = 5'h12;
  localparam int NUM_SOURCES = 19;
  localparam logic [NUM_SOURCES-1:0] FLAGS_RESET = '0;
endpackage : ext_irq_pkg

//--- edge_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Pin synchroniser and edge detector
// ----------------------------------------------------------------------------
module edge_sync
  import ext_irq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pins and edges
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  // First stage feeds only the second; resets high so idle-high pins give no edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else if (clk_en) begin
      meta_reg <= pin_in; // [RULE_19]
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Compare successive synchronised samples
  assign rise = sync_reg & ~prev_reg; // [RULE_19]
  assign fall = ~sync_reg & prev_reg; // [RULE_19]
endmodule : edge_sync

//--- external_edge_interrupt_select.sv
// Functional notes
// [RULE_01] Nineteen port pins can serve as external interrupt inputs.
// [RULE_02] Each pin selects rising, falling or both edges.
// [RULE_03] Priority from owning source control; grant reports that source's vector.
// [RULE_04] Software clears the pin direction bit so the pin is an input.
// [RULE_05] Channel mode 001b rising, 010b falling, 011b both sets channel flag.
// [RULE_06] Each selected channel edge latches the allocated base timer value.
// [RULE_07] Enabled set channel flag requests transfer or interrupt.
// [RULE_08] Auxiliary pin is an interrupt input only in mode 101b.
// [RULE_09] Aux input select X01b rising, X10b falling, X11b both.
// [RULE_10] Selected aux edge copies core timer count into aux register.
// [RULE_11] Enabled set aux flag requests transfer or interrupt.
// [RULE_12] Capture enable low: reload input edges only set the flag.
// [RULE_13] Reload edge field 01b rising, 10b falling, 11b both.
// [RULE_14] Enabled set reload flag requests interrupt or transfer.
// [RULE_15] Falling edge on non-maskable pin raises a hardware trap.
// [RULE_16] Traps cannot be masked and win over all interrupts.
// [RULE_17] Granted source has its request flag cleared when service starts.
// [RULE_18] Non-maskable edge sets a trap flag held until software clears.
// [RULE_19] Pins are synchronised and edges found from successive samples.
`timescale 1ns/1ps
module external_edge_interrupt_select
  import ext_irq_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter int TW = TIMER_WIDTH
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // External pins and direction bits
  input wire logic [NCH-1:0] capture_compare_unit_channel_pin,
  input wire logic aux_timer_a_input_pin,
  input wire logic aux_timer_b_input_pin,
  input wire logic reload_capture_input_pin,
  input wire logic nmi_n_pin,
  input wire logic [NCH+2:0] pin_direction_bit,
  // Channel configuration
  input wire logic [NCH*CH_MODE_WIDTH-1:0] channel_mode_field,
  input wire logic [NCH-1:0] channel_timer_select,
  input wire logic [NCH-1:0] channel_irq_enable,
  input wire logic [NCH*ICR_WIDTH-1:0] channel_irq_control,
  // Auxiliary and reload configuration
  input wire logic [2:0] aux_a_mode_field,
  input wire logic [2:0] aux_b_mode_field,
  input wire logic [2:0] aux_a_input_select,
  input wire logic [2:0] aux_b_input_select,
  input wire logic aux_a_irq_enable,
  input wire logic aux_b_irq_enable,
  input wire logic [ICR_WIDTH-1:0] aux_a_irq_control,
  input wire logic [ICR_WIDTH-1:0] aux_b_irq_control,
  input wire logic capture_enable_bit,
  input wire logic [1:0] reload_capture_edge_field,
  input wire logic reload_capture_irq_enable,
  input wire logic [ICR_WIDTH-1:0] reload_capture_irq_control,
  // Timer values
  input wire logic [TW-1:0] capture_compare_unit_base_timer_a,
  input wire logic [TW-1:0] capture_compare_unit_base_timer_b,
  input wire logic [TW-1:0] core_timer,
  input wire logic [TW-1:0] block_two_timer,
  // Service handshake and trap flag clear
  input wire logic [LEVEL_WIDTH-1:0] cpu_level,
  input wire logic service_start,
  input wire logic trap_flag_clear,
  // Request flags and captured values
  output logic [NCH-1:0] channel_request_flag,
  output logic aux_a_request_flag,
  output logic aux_b_request_flag,
  output logic reload_capture_request_flag,
  output logic [NCH*TW-1:0] channel_capture_register,
  output logic [TW-1:0] aux_a_capture,
  output logic [TW-1:0] aux_b_capture,
  output logic [TW-1:0] capture_reload_register,
  // Service request and trap
  output logic irq_valid,
  output logic irq_transfer,
  output logic [SRC_IDX_WIDTH-1:0] irq_source,
  output logic [LEVEL_WIDTH-1:0] irq_level,
  output logic trap_request,
  output logic nmi_trap_flag
);
  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  localparam int NP = NCH + 4;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;

  edge_sync #(.WIDTH(NP)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in({nmi_n_pin, reload_capture_input_pin, aux_timer_b_input_pin,
             aux_timer_a_input_pin, capture_compare_unit_channel_pin}),
    .rise(rise),
    .fall(fall)
  );

  // Edge match against a two-bit select; 00 never matches
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] & r) | (sel[1] & f); // [RULE_02]
  endfunction : edge_hit

  // Priority level field out of an interrupt control byte
  function automatic logic [LEVEL_WIDTH-1:0] lvl_of(input logic [ICR_WIDTH-1:0] icr);
    lvl_of = icr[ICR_LEVEL_MSB:ICR_LEVEL_LSB];
  endfunction : lvl_of

  // --------------------------------------------------------------------------
  // Per-source event decode
  // --------------------------------------------------------------------------
  logic [NCH-1:0] ch_evt;
  logic aux_a_evt;
  logic aux_b_evt;
  logic rel_evt;
  logic [2:0] ch_mode;

  // Pins used as outputs never yield events; software owns direction
  always_comb begin
    ch_evt = '0;
    ch_mode = '0;
    for (int i = 0; i < NCH; i++) begin
      ch_mode = channel_mode_field[i*CH_MODE_WIDTH +: CH_MODE_WIDTH];
      if (!pin_direction_bit[i] && ch_mode >= CH_MODE_CAP_RISE
          && ch_mode <= CH_MODE_CAP_BOTH) begin // [RULE_01] [RULE_04]
        ch_evt[i] = edge_hit(ch_mode[1:0], rise[i], fall[i]); // [RULE_05]
      end
    end
  end

  assign aux_a_evt = !pin_direction_bit[NCH] && aux_a_mode_field == AUX_MODE_CAPTURE
    && edge_hit(aux_a_input_select[AUX_SEL_EDGE_MSB:AUX_SEL_EDGE_LSB],
                rise[NCH], fall[NCH]); // [RULE_08] [RULE_09]
  assign aux_b_evt = !pin_direction_bit[NCH+1] && aux_b_mode_field == AUX_MODE_CAPTURE
    && edge_hit(aux_b_input_select[AUX_SEL_EDGE_MSB:AUX_SEL_EDGE_LSB],
                rise[NCH+1], fall[NCH+1]); // [RULE_08] [RULE_09]
  assign rel_evt = !pin_direction_bit[NCH+2]
    && edge_hit(reload_capture_edge_field, rise[NCH+2], fall[NCH+2]); // [RULE_13]

  // --------------------------------------------------------------------------
  // Capture registers
  // --------------------------------------------------------------------------
  // Channels latch their base timer whether it runs or not
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_capture_register <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_evt[i]) begin
          channel_capture_register[i*TW +: TW] <= channel_timer_select[i] ?
            capture_compare_unit_base_timer_b : capture_compare_unit_base_timer_a; // [RULE_06]
        end
      end
    end
  end

  // Auxiliary registers take the core timer count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_a_capture <= '0;
      aux_b_capture <= '0;
    end else if (clk_en) begin
      if (aux_a_evt) begin
        aux_a_capture <= core_timer; // [RULE_10]
      end
      if (aux_b_evt) begin
        aux_b_capture <= core_timer; // [RULE_10]
      end
    end
  end

  // Capture disabled keeps the register free for reload use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture_reload_register <= '0;
    end else if (clk_en) begin
      if (rel_evt && capture_enable_bit) begin // [RULE_12]
        capture_reload_register <= block_two_timer;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request flags and arbitration
  // --------------------------------------------------------------------------
  logic [NUM_SOURCES-1:0] flags;
  logic [NUM_SOURCES-1:0] evts;
  logic [NUM_SOURCES-1:0] enables;
  logic [NUM_SOURCES-1:0] grant_clr;
  logic win_valid;
  logic [SRC_IDX_WIDTH-1:0] win_idx;
  logic [LEVEL_WIDTH-1:0] win_lvl;
  logic win_xfer;
  logic [ICR_WIDTH-1:0] icr;

  assign evts = {rel_evt, aux_b_evt, aux_a_evt, ch_evt};
  assign enables = {reload_capture_irq_enable, aux_b_irq_enable, aux_a_irq_enable,
                    channel_irq_enable};

  // Highest level above the CPU wins; lowest index breaks ties
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    win_lvl = '0;
    win_xfer = 1'b0;
    icr = '0;
    for (int s = 0; s < NUM_SOURCES; s++) begin
      if (s < NCH) begin
        icr = channel_irq_control[s*ICR_WIDTH +: ICR_WIDTH];
      end else if (s == NCH) begin
        icr = aux_a_irq_control;
      end else if (s == NCH + 1) begin
        icr = aux_b_irq_control;
      end else begin
        icr = reload_capture_irq_control;
      end
      if (flags[s] && enables[s] && lvl_of(icr) > cpu_level // [RULE_07] [RULE_11] [RULE_14]
          && (!win_valid || lvl_of(icr) > win_lvl)) begin // [RULE_03]
        win_valid = 1'b1;
        win_idx = SRC_IDX_WIDTH'(s);
        win_lvl = lvl_of(icr);
        win_xfer = icr[ICR_XFER_BIT];
      end
    end
  end

  // A pending trap holds every interrupt off
  assign irq_valid = win_valid && !trap_request; // [RULE_16]
  assign irq_source = win_idx; // [RULE_03]
  assign irq_level = win_lvl;
  assign irq_transfer = win_xfer;
  assign grant_clr = (service_start && irq_valid) ?
    (NUM_SOURCES'(1) << win_idx) : '0;

  // Event sets win over a same-cycle service clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RESET;
    end else if (clk_en) begin
      flags <= (flags & ~grant_clr) | evts; // [RULE_17]
    end
  end

  assign channel_request_flag = flags[NCH-1:0];
  assign aux_a_request_flag = flags[NCH];
  assign aux_b_request_flag = flags[NCH+1];
  assign reload_capture_request_flag = flags[NCH+2];

  // --------------------------------------------------------------------------
  // Non-maskable trap
  // --------------------------------------------------------------------------
  // No enable or level gates this flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmi_trap_flag <= 1'b0;
    end else if (clk_en) begin
      if (fall[NCH+3]) begin
        nmi_trap_flag <= 1'b1; // [RULE_15] [RULE_18]
      end else if (trap_flag_clear) begin
        nmi_trap_flag <= 1'b0;
      end
    end
  end

  assign trap_request = nmi_trap_flag; // [RULE_16]

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_trap_blocks_irq: assert property (@(posedge clk) disable iff (sys_rst)
    trap_request |-> !irq_valid) // [RULE_16]
    else $error("interrupt offered while trap pending");
  a_nmi_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fall[NCH+3] |=> nmi_trap_flag) // [RULE_15]
    else $error("nmi edge did not set trap flag");
  a_nmi_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
    nmi_trap_flag && !trap_flag_clear |=> nmi_trap_flag) // [RULE_18]
    else $error("trap flag dropped without clear");
  a_grant_clears: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && grant_clr != '0 && (grant_clr & evts) == '0
      |=> (flags & $past(grant_clr)) == '0) // [RULE_17]
    else $error("granted flag not cleared");
  a_aux_mode_gate: assert property (@(posedge clk) disable iff (sys_rst)
    aux_a_mode_field != AUX_MODE_CAPTURE |-> !aux_a_evt) // [RULE_08]
    else $error("aux event outside capture mode");
  a_aux_capture: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && aux_a_evt |=> aux_a_capture == $past(core_timer)) // [RULE_10]
    else $error("aux capture wrong");
  a_reload_keep: assert property (@(posedge clk) disable iff (sys_rst)
    !capture_enable_bit |=> $stable(capture_reload_register)) // [RULE_12]
    else $error("reload register captured while disabled");
  a_ch_capture: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && ch_evt[0] |=> channel_capture_register[TW-1:0] ==
      ($past(channel_timer_select[0]) ? $past(capture_compare_unit_base_timer_b)
                                      : $past(capture_compare_unit_base_timer_a))) // [RULE_06]
    else $error("channel capture wrong");
  a_ch_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && ch_evt[0] |=> channel_request_flag[0]) // [RULE_05]
    else $error("channel flag not set");
  c_channel_irq: cover property (@(posedge clk) irq_valid && irq_source < SRC_AUX_A);
  c_aux_irq: cover property (@(posedge clk) irq_valid && irq_source == SRC_AUX_B);
  c_reload_irq: cover property (@(posedge clk) irq_valid && irq_source == SRC_RELOAD);
  c_trap: cover property (@(posedge clk) trap_request);
endmodule : external_edge_interrupt_select

//--- ext_pin_source.sv
`timescale 1ns/1ps
module ext_pin_source (
  // Clock
  input wire logic clk,
  // Levels asked for by the bench: nmi, reload, aux b, aux a, channels
  input wire logic [19:0] want,
  // Pins
  output logic [15:0] ch_pin,
  output logic aux_a_pin,
  output logic aux_b_pin,
  output logic reload_pin,
  output logic nmi_n
);
  // Sources move only on the falling edge, half a cycle from any sampling;
  // the bench asks for idle-high levels, matching the synchroniser's reset state
  always @(negedge clk) begin
    {nmi_n, reload_pin, aux_b_pin, aux_a_pin, ch_pin} <= want;
  end
endmodule : ext_pin_source

//--- external_edge_interrupt_select_bench.sv
`timescale 1ns/1ps
module external_edge_interrupt_select_bench;
  import ext_irq_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 0, sys_rst = 1, clk_en = 1, service_start = 0, trap_flag_clear = 0;
  logic [19:0] want = '1;
  logic [18:0] pin_direction_bit = '0;
  logic [47:0] channel_mode_field = '0;
  logic [15:0] channel_timer_select = '0, channel_irq_enable = '1;
  logic [127:0] channel_irq_control = '0;
  logic [2:0] aux_a_mode_field = '0, aux_b_mode_field = '0;
  logic [2:0] aux_a_input_select = '0, aux_b_input_select = '0;
  logic aux_a_irq_enable = 1, aux_b_irq_enable = 1;
  logic capture_enable_bit = 0, reload_capture_irq_enable = 1;
  logic [7:0] aux_a_irq_control = '0, aux_b_irq_control = '0;
  logic [7:0] reload_capture_irq_control = '0, cur_ctl = '0;
  logic [1:0] reload_capture_edge_field = '0;
  logic [15:0] capture_compare_unit_base_timer_a = '0, capture_compare_unit_base_timer_b = '0;
  logic [15:0] core_timer = '0, block_two_timer = '0;
  logic [3:0] cpu_level = '0, irq_level;
  logic [15:0] capture_compare_unit_channel_pin, channel_request_flag;
  logic aux_timer_a_input_pin, aux_timer_b_input_pin, reload_capture_input_pin, nmi_n_pin;
  logic aux_a_request_flag, aux_b_request_flag, reload_capture_request_flag;
  logic irq_valid, irq_transfer, trap_request, nmi_trap_flag;
  logic [255:0] channel_capture_register;
  logic [15:0] aux_a_capture, aux_b_capture, capture_reload_register;
  logic [4:0] irq_source;
  logic [18:0] fl;
  int num_errors = 0, n_checks = 0;
  assign fl = {reload_capture_request_flag, aux_b_request_flag, aux_a_request_flag,
               channel_request_flag};
  always #5 clk = ~clk;
  ext_pin_source src (.clk, .want, .ch_pin(capture_compare_unit_channel_pin),
    .aux_a_pin(aux_timer_a_input_pin), .aux_b_pin(aux_timer_b_input_pin),
    .reload_pin(reload_capture_input_pin), .nmi_n(nmi_n_pin));
  external_edge_interrupt_select DUT (.clk, .sys_rst, .clk_en, .capture_compare_unit_channel_pin,
    .aux_timer_a_input_pin, .aux_timer_b_input_pin, .reload_capture_input_pin, .nmi_n_pin,
    .pin_direction_bit, .channel_mode_field, .channel_timer_select, .channel_irq_enable,
    .channel_irq_control, .aux_a_mode_field, .aux_b_mode_field, .aux_a_input_select,
    .aux_b_input_select, .aux_a_irq_enable, .aux_b_irq_enable, .aux_a_irq_control,
    .aux_b_irq_control, .capture_enable_bit, .reload_capture_edge_field,
    .reload_capture_irq_enable, .reload_capture_irq_control, .capture_compare_unit_base_timer_a,
    .capture_compare_unit_base_timer_b, .core_timer, .block_two_timer, .cpu_level, .service_start,
    .trap_flag_clear, .channel_request_flag, .aux_a_request_flag, .aux_b_request_flag,
    .reload_capture_request_flag, .channel_capture_register, .aux_a_capture,
    .aux_b_capture, .capture_reload_register, .irq_valid, .irq_transfer, .irq_source,
    .irq_level, .trap_request, .nmi_trap_flag);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic nclk(int n);
    repeat (n) @(negedge clk);
  endtask : nclk
  function automatic logic [15:0] cap(int i);
    if (i < 16) return channel_capture_register[i*16+:16];
    return i == 16 ? aux_a_capture : i == 17 ? aux_b_capture : capture_reload_register;
  endfunction : cap
  // Program the edge code and control of one source; code 0 disables it
  task automatic cfg(int i, logic [1:0] e, logic [7:0] ctl);
    if (i < 16) begin
      channel_mode_field[i*3+:3] <= {1'b0, e};
      channel_irq_control[i*8+:8] <= ctl;
    end else if (i == 16) begin
      aux_a_mode_field <= AUX_MODE_CAPTURE;
      aux_a_input_select <= {1'($urandom), e}; // Top bit must not matter
      aux_a_irq_control <= ctl;
    end else if (i == 17) begin
      aux_b_mode_field <= AUX_MODE_CAPTURE;
      aux_b_input_select <= {1'($urandom), e};
      aux_b_irq_control <= ctl;
    end else begin
      reload_capture_edge_field <= e;
      reload_capture_irq_control <= ctl;
    end
  endtask : cfg
  // Move one pin, check the flag, and for a hit the grant, capture and clear
  task automatic ev(int i, logic lvl, logic hit);
    logic [15:0] old;
    logic [15:0] exp;
    old = cap(i);
    capture_compare_unit_base_timer_a <= 16'($urandom);
    capture_compare_unit_base_timer_b <= 16'($urandom);
    core_timer <= 16'($urandom);
    block_two_timer <= 16'($urandom);
    channel_timer_select <= 16'($urandom);
    want[i] <= lvl;
    nclk(5);
    chk("flag", 16'(fl[i]), 16'(hit));
    if (hit) begin
      if (i < 16) exp = channel_timer_select[i] ? capture_compare_unit_base_timer_b : capture_compare_unit_base_timer_a;
      else if (i < 18) exp = core_timer;
      else exp = capture_enable_bit ? block_two_timer : old;
      chk("capture", cap(i), exp);
      chk("irq_valid", 16'(irq_valid), 16'h1);
      chk("source", 16'(irq_source), 16'(i));
      chk("level", 16'(irq_level), 16'(cur_ctl[5:2]));
      chk("transfer", 16'(irq_transfer), 16'(cur_ctl[6]));
      service_start <= 1;
      nclk(1);
      service_start <= 0;
      nclk(1);
      chk("cleared", 16'(fl[i]), 16'h0);
    end
  endtask : ev
  task automatic test_done();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h23c0ed63));
    nclk(12);
    sys_rst <= 0;
    nclk(1);
    // Every source with edge codes 1 to 3; pins idle high, so fall then rise
    for (int i = 0; i < 19; i++) begin
      for (int e = 1; e < 4; e++) begin
        cur_ctl = {1'b0, 1'($urandom), 4'(1 + $urandom % 15), 2'b0};
        capture_enable_bit <= 1'($urandom);
        cfg(i, 2'(e), cur_ctl);
        nclk(1);
        ev(i, 1'b0, e[1]);
        ev(i, 1'b1, e[0]);
        cfg(i, 2'h0, cur_ctl);
        nclk(1);
      end
    end
    // Refusals: pin set as output, and an aux timer outside capture mode
    for (int k = 0; k < 4; k++) begin
      automatic int i = int'($urandom % 19);
      pin_direction_bit[i] <= 1'b1;
      cfg(i, EDGE_BOTH, cur_ctl);
      nclk(1);
      ev(i, 1'b0, 1'b0);
      ev(i, 1'b1, 1'b0);
      pin_direction_bit[i] <= 1'b0;
      cfg(i, 2'h0, cur_ctl);
      nclk(1);
    end
    cfg(16, EDGE_BOTH, cur_ctl);
    nclk(1);
    aux_a_mode_field <= 3'h4;
    nclk(1);
    ev(16, 1'b0, 1'b0);
    ev(16, 1'b1, 1'b0);
    // Two pending sources, a masking level, then a trap on top
    cfg(3, EDGE_FALL, 8'h14);
    cfg(7, EDGE_FALL, 8'h24);
    want[3] <= 0;
    want[7] <= 0;
    nclk(5);
    chk("winner", 16'(irq_source), 16'h7);
    cpu_level <= 4'h9;
    nclk(1);
    chk("masked", 16'(irq_valid), 16'h0);
    cpu_level <= 4'h0;
    want[19] <= 0;
    nclk(5);
    chk("trap", {trap_request, nmi_trap_flag, irq_valid}, 16'h6);
    want[19] <= 1;
    nclk(5);
    chk("trap held", 16'(nmi_trap_flag), 16'h1);
    trap_flag_clear <= 1;
    nclk(1);
    trap_flag_clear <= 0;
    nclk(1);
    chk("trap clear", {trap_request, nmi_trap_flag}, 16'h0);
    service_start <= 1;
    nclk(1);
    service_start <= 0;
    chk("next", 16'(irq_source), 16'h3);
    want[3] <= 1;
    want[7] <= 1;
    nclk(5);
    // Clock enable low freezes the synchroniser; the edge is seen once it returns
    cfg(0, EDGE_FALL, 8'h3c);
    clk_en <= 0;
    want[0] <= 0;
    nclk(6);
    chk("frozen", 16'(fl[0]), 16'h0);
    clk_en <= 1;
    nclk(5);
    chk("thawed", 16'(fl[0]), 16'h1);
    chk("enabled", 16'(irq_source), 16'h0);
    // A pending flag with its enable cleared must not be offered
    channel_irq_enable[0] <= 1'b0;
    nclk(1);
    chk("disabled", 16'(irq_source), 16'h3);
    test_done();
  end
  // Whole run is under a thousand cycles; this cuts a hang well past that
  initial begin
    #300000;
    num_errors++;
    test_done();
  end
endmodule : external_edge_interrupt_select_bench
